// file: src/lin_cfg_map.svh
/*
  Register map, field positions and constants of the LIN channel
  configuration block. Included by bare name; definitions only.
*/
`ifndef LIN_CFG_MAP_SVH
`define LIN_CFG_MAP_SVH

// Register addresses carried in frame bits 13-9.
`define LIN1_ADDR   5'h13
`define CHAN2_ADDR  5'h14
// Write code carried in frame bits 15-14.
`define WR_CODE     2'h1
`define FRAME_BITS  5'h10
`define CNT_MAX     5'h1f
`define CNT_ONE     5'h01
`define CNT_ZERO    5'h00
`define SHIFT_RESET 16'h0000
// Field positions inside a channel register.
`define MODE_HI     7
`define MODE_LO     6
`define SLEW_HI     5
`define SLEW_LO     4
`define TERM_BIT    2
`define KEEP_BIT    0
// Frame field positions.
`define CMD_HI      15
`define CMD_LO      14
`define ADDR_HI     13
`define ADDR_LO     9
`define DATA_HI     7
// Mode field codes.
`define MODE_OFF    2'h0
`define MODE_WAKE   2'h2
`define MODE_TXRX   2'h3
// Reset value and writable-bit mask; bits 3 and 1 read as zero.
`define CFG_RESET   8'h00
`define CFG_MASK    8'hf5
// Synchroniser vector layout and reset value (select idle high).
`define IN_SCLK     0
`define IN_SEL_N    1
`define IN_MOSI     2
`define IN_TXD      3
`define IN_SUPLOW   5
`define IN_CANREG   7
`define SYNC_W      8
`define SYNC_RESET  8'h1a

`endif

// file: src/lin_cfg_pkg.sv
/*
  Types of the LIN channel configuration block.
  Assumes the map header supplies all numeric constants.
*/
package lin_cfg_pkg;

  // Slope selection driven to the analog transmitter.
  typedef enum logic [1:0] {
    SLEW_20K  = 2'h0,
    SLEW_10K  = 2'h1,
    SLEW_FAST = 2'h2
  } slew_t;

  // Serial frame receiver states, one-hot.
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b01,
    FR_SHIFT = 2'b10
  } frame_state_t;

endpackage

// file: src/lin_channel_config_regs.sv
/*
  Configuration registers of the two LIN channels, written by 16-bit
  serial frames from the microcontroller, with the transmit/receive
  interlock and the low-supply recessive forcing.
  Assumes serial pins and analog status levels are asynchronous to
  ref_clk and that the serial clock is well below ref_clk / 4.
*/
// Behaviour
// R1: Mode 00 off with wake off, 10 off with wake on, 11 transmit/receive.
// R2: Slew 00 selects 20 kbit/s, 01 10 kbit/s, 10 and 11 fast slope.
// R3: Bit 2 switches the bus termination off (0) or on (1).
// R4: Keep-alive 0: force output recessive while the supply is below 6.0 V.
// R5: Keep-alive 1: keep running below 6.0 V until CAN regulator stops.
// R6: Transmit/receive mode write accepted only with transmit input recessive.
// R7: Microcontroller switches the CAN regulator on before using LIN.
// R8: Write frame is 16 bits: code 01, address, flag, eight data bits.
// R9: Power-on reset clears every field: off, no wake, 20 kbit/s, no term.
`timescale 1ns/10ps
`include "lin_cfg_map.svh"

// ********************************************************************
// One channel register with its decode
// ********************************************************************
module lin_channel_slot #(
  parameter logic [4:0] ADDR = `LIN1_ADDR
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Write request from the frame receiver
  input  wire logic                wrStrobe,
  input  wire logic [4:0]          wrAddr,
  input  wire logic [7:0]          wrData,
  // Synchronised channel status
  input  wire logic                txdRecessive,
  input  wire logic                supplyLow,
  input  wire logic                canRegOn,
  // Register and decoded controls
  output logic      [7:0]          cfgReg,
  output logic                     txRxEnable,
  output logic                     wakeEnable,
  output lin_cfg_pkg::slew_t       slewSel,
  output logic                     termOn,
  output logic                     forceRecessive
);

  logic hit;
  logic [1:0] wrMode;

  assign hit    = wrStrobe && (wrAddr == ADDR);
  assign wrMode = wrData[`MODE_HI:`MODE_LO];

  // Register update; reserved bits are masked so they read as zero.
  // R9: reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgReg <= `CFG_RESET;
    end else if (hit) begin
      cfgReg <= wrData & `CFG_MASK;
      // R6: refuse transmit/receive while the transmit input is dominant.
      if (wrMode == `MODE_TXRX && !txdRecessive) begin
        cfgReg[`MODE_HI:`MODE_LO] <= `MODE_OFF;
      end
    end
  end

  // R1: mode decode. Code 01 is unused and behaves as off.
  assign txRxEnable = (cfgReg[`MODE_HI:`MODE_LO] == `MODE_TXRX);
  assign wakeEnable = (cfgReg[`MODE_HI:`MODE_LO] == `MODE_WAKE);

  // R2: slope decode. Both upper codes map onto the fast slope.
  always_comb begin
    case (cfgReg[`SLEW_HI:`SLEW_LO])
      2'h0:    slewSel = lin_cfg_pkg::SLEW_20K;
      2'h1:    slewSel = lin_cfg_pkg::SLEW_10K;
      default: slewSel = lin_cfg_pkg::SLEW_FAST;
    endcase
  end

  // R3: termination switch
  assign termOn = cfgReg[`TERM_BIT];

  // R4: low supply without keep-alive forces recessive.
  // R5: with keep-alive, only loss of the CAN regulator stops the channel.
  assign forceRecessive = cfgReg[`KEEP_BIT] ? !canRegOn : supplyLow;

  // Writes that land in this register, by mode value.
  sequence wrModeSeq(logic [1:0] m, logic txd);
    hit && wrMode == m && txdRecessive == txd;
  endsequence

  modeTxRx_a: assert property (@(posedge clk) disable iff (rst) // R1
    wrModeSeq(`MODE_TXRX, 1'b1) |=> txRxEnable && !wakeEnable)
    else $error("Accepted transmit/receive write not applied.");

  modeWake_a: assert property (@(posedge clk) disable iff (rst) // R1
    wrModeSeq(`MODE_WAKE, 1'b1) |=> wakeEnable && !txRxEnable)
    else $error("Wake-only mode write not applied.");

  txdInterlock_a: assert property (@(posedge clk) disable iff (rst) // R6
    wrModeSeq(`MODE_TXRX, 1'b0) |=> !txRxEnable && !wakeEnable)
    else $error("Transmit/receive mode taken while input dominant.");

  slewSelect_a: assert property (@(posedge clk) disable iff (rst) // R2
    hit && wrData[`SLEW_HI:`SLEW_LO] == 2'h1
      |=> slewSel == lin_cfg_pkg::SLEW_10K ##1 !hit [*1])
    else $error("Slope select 10 kbit/s not applied.");

  termWrite_a: assert property (@(posedge clk) disable iff (rst) // R3
    hit |=> termOn == $past(wrData[`TERM_BIT]))
    else $error("Termination bit not applied.");

  lowSupply_a: assert property (@(posedge clk) disable iff (rst) // R4
    !cfgReg[`KEEP_BIT] && supplyLow |-> forceRecessive)
    else $error("Low supply did not force recessive.");

  keepAlive_a: assert property (@(posedge clk) disable iff (rst) // R5
    cfgReg[`KEEP_BIT] && canRegOn |-> !forceRecessive)
    else $error("Keep-alive channel forced recessive.");

  resetZero_a: assert property (@(posedge clk) disable iff (rst) // R9
    $past(rst) |-> cfgReg == `CFG_RESET && slewSel == lin_cfg_pkg::SLEW_20K)
    else $error("Register not zero after reset.");

endmodule

// ********************************************************************
// Top: serial frame receiver and the two channel registers
// ********************************************************************
module lin_channel_config_regs (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // Serial write port from the microcontroller
  input  wire logic                spiClk,
  input  wire logic                spiSelN,
  input  wire logic                spiMosi,
  // Channel status pins, index 0 is the first channel
  input  wire logic [1:0]          txdIn,
  input  wire logic [1:0]          supplyLow,
  input  wire logic                canRegOn,
  // First channel
  output logic      [7:0]          lin1Config,
  output logic                     lin1TxRxEnable,
  output logic                     lin1WakeEnable,
  output lin_cfg_pkg::slew_t       lin1SlewSel,
  output logic                     lin1TermOn,
  output logic                     lin1ForceRecessive,
  // Second channel
  output logic      [7:0]          chan2Config,
  output logic                     chan2TxRxEnable,
  output logic                     chan2WakeEnable,
  output lin_cfg_pkg::slew_t       chan2SlewSel,
  output logic                     second_channel_termination_enable,
  output logic                     chan2ForceRecessive
);

  logic [`SYNC_W-1:0]        syncA;
  logic [`SYNC_W-1:0]        syncB;
  logic                      sclkPrev;
  logic                      selPrev;
  logic                      sclkRise;
  logic                      selRise;
  logic                      selFall;
  logic [15:0]               shiftReg;
  logic [4:0]                bitCnt;
  logic                      wrStrobe;
  lin_cfg_pkg::frame_state_t state;

  // Two-flop synchroniser; only syncB feeds any logic.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= `SYNC_RESET;
      syncB <= `SYNC_RESET;
    end else begin
      syncA <= {canRegOn, supplyLow, txdIn, spiMosi, spiSelN, spiClk};
      syncB <= syncA;
    end
  end

  // Edge history of serial clock and select.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkPrev <= 1'b0;
      selPrev  <= 1'b1;
    end else begin
      sclkPrev <= syncB[`IN_SCLK];
      selPrev  <= syncB[`IN_SEL_N];
    end
  end

  assign sclkRise = syncB[`IN_SCLK] && !sclkPrev;
  assign selRise  = syncB[`IN_SEL_N] && !selPrev;
  assign selFall  = !syncB[`IN_SEL_N] && selPrev;

  // Frame state machine: a frame runs from select falling to rising.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= lin_cfg_pkg::FR_IDLE;
    end else begin
      case (state)
        lin_cfg_pkg::FR_IDLE:
          if (selFall) state <= lin_cfg_pkg::FR_SHIFT;
        lin_cfg_pkg::FR_SHIFT:
          if (selRise) state <= lin_cfg_pkg::FR_IDLE;
        default: state <= lin_cfg_pkg::FR_IDLE;
      endcase
    end
  end

  // Shift MSB first on rising serial clock; count saturates so that
  // over-long frames can never look like 16 bits again.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftReg <= `SHIFT_RESET;
      bitCnt   <= `CNT_ZERO;
    end else if (selFall) begin
      bitCnt <= `CNT_ZERO;
    end else if (state == lin_cfg_pkg::FR_SHIFT && sclkRise) begin
      shiftReg <= {shiftReg[14:0], syncB[`IN_MOSI]};
      if (bitCnt != `CNT_MAX) bitCnt <= bitCnt + `CNT_ONE;
    end
  end

  // R8: a write is a complete 16-bit frame carrying code 01.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrStrobe <= 1'b0;
    end else begin
      wrStrobe <= state == lin_cfg_pkg::FR_SHIFT && selRise &&
                  bitCnt == `FRAME_BITS &&
                  shiftReg[`CMD_HI:`CMD_LO] == `WR_CODE;
    end
  end

  sequence goodFrame;
    state == lin_cfg_pkg::FR_SHIFT && selRise && bitCnt == `FRAME_BITS;
  endsequence

  frameWrite_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    goodFrame ##0 shiftReg[`CMD_HI:`CMD_LO] == `WR_CODE |=> wrStrobe)
    else $error("Valid write frame produced no write.");

  frameLength_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    selRise && bitCnt != `FRAME_BITS |=> !wrStrobe)
    else $error("Frame of wrong length was written.");

  lin_channel_slot #(.ADDR(`LIN1_ADDR)) chan1 (
    .clk            (ref_clk),
    .rst            (sys_rst),
    .wrStrobe       (wrStrobe),
    .wrAddr         (shiftReg[`ADDR_HI:`ADDR_LO]),
    .wrData         (shiftReg[`DATA_HI:0]),
    .txdRecessive   (syncB[`IN_TXD]),
    .supplyLow      (syncB[`IN_SUPLOW]),
    .canRegOn       (syncB[`IN_CANREG]),
    .cfgReg         (lin1Config),
    .txRxEnable     (lin1TxRxEnable),
    .wakeEnable     (lin1WakeEnable),
    .slewSel        (lin1SlewSel),
    .termOn         (lin1TermOn),
    .forceRecessive (lin1ForceRecessive)
  );

  lin_channel_slot #(.ADDR(`CHAN2_ADDR)) chan2 (
    .clk            (ref_clk),
    .rst            (sys_rst),
    .wrStrobe       (wrStrobe),
    .wrAddr         (shiftReg[`ADDR_HI:`ADDR_LO]),
    .wrData         (shiftReg[`DATA_HI:0]),
    .txdRecessive   (syncB[`IN_TXD+1]),
    .supplyLow      (syncB[`IN_SUPLOW+1]),
    .canRegOn       (syncB[`IN_CANREG]),
    .cfgReg         (chan2Config),
    .txRxEnable     (chan2TxRxEnable),
    .wakeEnable     (chan2WakeEnable),
    .slewSel        (chan2SlewSel),
    .termOn         (second_channel_termination_enable),
    .forceRecessive (chan2ForceRecessive)
  );

endmodule

// file: verif/spi_master_model.sv
/*
  Microcontroller model that writes 16-bit serial frames, MSB first.
  Assumes ref_clk is free running; each serial phase lasts 4 cycles.
*/
`timescale 1ns/10ps

// ****************************************
// Serial master driven by the bench
// ****************************************
module spi_master_model (
  // Timing reference
  input  wire logic ref_clk,
  // Serial pins
  output logic      spiClk,
  output logic      spiSelN,
  output logic      spiMosi
);
  // The clock stands low and select high outside frames.
  initial begin
    spiClk  = 1'b0;
    spiSelN = 1'b1;
    spiMosi = 1'b0;
  end

  // Waits one serial phase and steps just past the edge.
  task automatic pause();
    repeat (4) @(posedge ref_clk);
    #2;
  endtask

  // frame layout sent
  // Sends the top n bits of f; fewer than 16 only to be refused.
  task automatic send(input logic [15:0] f, input int n);
    int i;
    @(posedge ref_clk);
    #2;
    spiSelN = 1'b0;
    for (i = 15; i > 15 - n; i--) begin
      spiMosi = f[i];
      pause();
      spiClk = 1'b1;
      pause();
      spiClk = 1'b0;
    end
    pause();
    spiSelN = 1'b1;
    spiMosi = ~spiMosi; // Released line must not keep the last bit.
    pause();
    pause();
  endtask
endmodule

// file: verif/lin_channel_config_regs_test.sv
/*
  Self-checking bench of the LIN channel configuration registers.
  Assumes the serial master model and the map header of the design.
*/
`timescale 1ns/10ps
`include "lin_cfg_map.svh"

module lin_channel_config_regs_test;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [1:0]  txdIn = 2'h3;
  logic [1:0]  supplyLow = 2'h0;
  logic        canRegOn = 1'b0;
  logic        spiClk, spiSelN, spiMosi;
  wire  [27:0] seen;
  logic [27:0] expQ[$];
  logic [7:0]  shadow[2];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          seed = 80528;
  int          i;
  event        sampleEv;

  always #12.5 ref_clk = ~ref_clk;

  spi_master_model u_mcu (.ref_clk(ref_clk), .spiClk(spiClk),
    .spiSelN(spiSelN), .spiMosi(spiMosi));

  lin_channel_config_regs u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .spiClk(spiClk),
    .spiSelN(spiSelN), .spiMosi(spiMosi), .txdIn(txdIn),
    .supplyLow(supplyLow), .canRegOn(canRegOn),
    .lin1Config(seen[27:20]), .lin1TxRxEnable(seen[19]),
    .lin1WakeEnable(seen[18]), .lin1SlewSel(seen[17:16]),
    .lin1TermOn(seen[15]), .lin1ForceRecessive(seen[14]),
    .chan2Config(seen[13:6]), .chan2TxRxEnable(seen[5]),
    .chan2WakeEnable(seen[4]), .chan2SlewSel(seen[3:2]),
    .second_channel_termination_enable(seen[1]),
    .chan2ForceRecessive(seen[0]));

  // Expected decode of one channel from its stored byte and status.
  function automatic logic [13:0] dec(input logic [7:0] c, input int ch);
    lin_cfg_pkg::slew_t s;
    s = c[5] ? lin_cfg_pkg::SLEW_FAST :
        (c[4] ? lin_cfg_pkg::SLEW_10K : lin_cfg_pkg::SLEW_20K);
    return {c, c[7:6] == 2'h3, c[7:6] == 2'h2, s, c[2],
            c[0] ? ~canRegOn : supplyLow[ch]};
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Notes the expectation, lets the result settle, then asks for a look.
  task automatic note();
    expQ.push_back({dec(shadow[0], 0), dec(shadow[1], 1)});
    repeat (8) @(posedge ref_clk);
    #2;
    ->sampleEv;
  endtask

  // interlock on mode 11
  // Sends a frame and updates the shadow only when it must be taken.
  task automatic wr(input logic [1:0] code, input logic [4:0] a,
                    input logic [7:0] d, input int n);
    logic [7:0] v;
    int         ch;
    ch = (a == `CHAN2_ADDR) ? 1 : 0;
    u_mcu.send({code, a, 1'b0, d}, n);
    if (n == 16 && code == `WR_CODE &&
        (a == `LIN1_ADDR || a == `CHAN2_ADDR)) begin
      v = d & `CFG_MASK;
      if (v[7:6] == 2'h3 && !txdIn[ch])
        v[7:6] = 2'h0;
      shadow[ch] = v;
    end
    note();
  endtask

  // Takes the oldest note whenever a result is due and compares.
  always @(sampleEv) begin
    check(seen, expQ.pop_front());
  end

  // Closes the run with the counts and the verdict.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hang costs at most about 40000 cycles.
  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end

  initial begin
    shadow[0] = `CFG_RESET;
    shadow[1] = `CFG_RESET;
    repeat (6) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    note();
    $display("Test reset done");
    canRegOn = 1'b1;
    // Every mode and slew code on both channels, status at random.
    for (i = 0; i < 32; i++) begin
      txdIn = $random(seed);
      supplyLow = $random(seed);
      if (i % 8 == 7)
        canRegOn = $random(seed);
      wr(`WR_CODE, i[0] ? `CHAN2_ADDR : `LIN1_ADDR,
         {i[4:1], 4'($random(seed))}, 16);
    end
    $display("Test codes done");
    // Refusals: other codes, unknown address, short frame.
    txdIn = 2'h3;
    wr(2'h0, `CHAN2_ADDR, 8'hf5, 16);
    wr(2'h2, `CHAN2_ADDR, 8'hf5, 16);
    wr(2'h3, `LIN1_ADDR, 8'hf5, 16);
    wr(`WR_CODE, 5'h15, 8'hf5, 16);
    wr(`WR_CODE, `CHAN2_ADDR, 8'hf5, 15);
    // Mode 11 refused then taken back to back on the second channel.
    txdIn = 2'h1;
    wr(`WR_CODE, `CHAN2_ADDR, 8'hc5, 16);
    txdIn = 2'h3;
    wr(`WR_CODE, `CHAN2_ADDR, 8'hc5, 16);
    $display("Test refusals done");
    end_sim();
  end
endmodule
